// [verilog/pbcs_pkg.sv]
package pbcs_pkg;
  localparam int unsigned OSC_DIV = 14;
  localparam int unsigned SLEEP_UNIT = 1024;
  localparam int unsigned SLEEP_XFACT = 8;
  localparam logic [4:0] SLEEP_PERM = 5'h1F;
  localparam logic [4:0] SLEEP_RST = 5'h00;
  localparam logic [1:0] BR_RST = 2'h0;
  localparam logic [1:0] NBIT_RST = 2'h0;
  localparam logic [4:0] LIM_MIN_RST = 5'h0A;
  localparam logic [4:0] LIM_MAX_RST = 5'h18;
  localparam int unsigned STARTUP_XT = 16;
  localparam logic [5:0] LIM_MAX_TOP = 6'h3F;

  // Edge-interval checks for the check bit count field: six per step of the field
  function automatic logic [4:0] pbcs_checks(input logic [1:0] nbit);
    case (nbit)
      2'h0: pbcs_checks = 5'h00;
      2'h1: pbcs_checks = 5'h06;
      2'h2: pbcs_checks = 5'h0C;
      default: pbcs_checks = 5'h12;
    endcase
  endfunction

  typedef enum logic [3:0] {
    PBCS_SLEEP = 4'b0001,
    PBCS_START = 4'b0010,
    PBCS_CHECK = 4'b0100,
    PBCS_RECV = 4'b1000
  } pbcs_state_t;
endpackage

// [verilog/pbcs_if.sv]
`timescale 1ns/1ns
interface pbcs_if;
  logic poll_override_n;
  logic back_to_poll;
  logic cfg_we;
  logic [4:0] cfg_sleep;
  logic cfg_sleep_ext;
  logic [1:0] cfg_baud;
  logic [1:0] cfg_nbit;
  logic [4:0] cfg_lim_min;
  logic [4:0] cfg_lim_max;
  logic demod_out;
  logic activity_indicator_pin;
  logic receiving;
  modport device (
    input poll_override_n, back_to_poll, cfg_we, cfg_sleep, cfg_sleep_ext,
    input cfg_baud, cfg_nbit, cfg_lim_min, cfg_lim_max, demod_out,
    output activity_indicator_pin, receiving
  );
  modport host (
    output poll_override_n, back_to_poll, cfg_we, cfg_sleep, cfg_sleep_ext,
    output cfg_baud, cfg_nbit, cfg_lim_min, cfg_lim_max,
    input activity_indicator_pin, receiving
  );
endinterface

// [verilog/pbcs_tick_gen.sv]
`timescale 1ns/1ns
module pbcs_tick_gen (
  input wire logic clk, // Oscillator clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [1:0] baud_range_select, // Baud range 0..3
  output logic base_tick, // One pulse per 14 oscillator periods
  output logic extended_tick // One pulse per 8/4/2/1 base ticks
);
  import pbcs_pkg::*;
  logic [3:0] div_q, div_d;
  logic [2:0] ext_q, ext_d;
  logic base_q, base_d, ext_tk_q, ext_tk_d;
  logic [2:0] ext_last;

  always_comb begin
    case (baud_range_select)
      2'h0: ext_last = 3'h7;
      2'h1: ext_last = 3'h3;
      2'h2: ext_last = 3'h1;
      default: ext_last = 3'h0;
    endcase
    base_d = (div_q == 4'(OSC_DIV - 1));
    div_d = base_d ? 4'h0 : div_q + 4'h1;
    ext_d = ext_q;
    ext_tk_d = 1'b0;
    if (base_d) begin
      ext_tk_d = (ext_q >= ext_last);
      ext_d = ext_tk_d ? 3'h0 : ext_q + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 4'h0;
      ext_q <= 3'h0;
      base_q <= 1'b0;
      ext_tk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_q <= ext_d;
      base_q <= base_d;
      ext_tk_q <= ext_tk_d;
    end
  end

  assign base_tick = base_q;
  assign extended_tick = ext_tk_q;
endmodule

// [verilog/pbcs_device.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - base tick is oscillator divided by fourteen
// - extended tick is 8,4,2,1 base ticks
// - polling cycles sleep, start-up, bit-check
// - processing off in sleep, on from start-up
// - activity output shows sleeping or active
// - sleep equals value times factor times 1024
// - extension factor eight when select bit set
// - highest sleep value means permanent sleep
// - override pin wakes receiver in permanent sleep
// - bit-check times each demodulator edge interval
// - check field selects 0,6,12,18 interval checks
// - enough passed checks enter receiving mode
// - interval inside window is accepted
// - too short or reaching upper fails to sleep
// - limits are five-bit, scaled by extended tick
// - host keeps lower limit at least ten
// - counter steps per extended tick; start-up ignored
// - host picks more bits for small limits; pbcs_host passes usr_nbit through unchanged
// - host sets window about thirty percent wide; pbcs_host takes usr_lim_max as given
// - receiving holds until commanded back to polling
// - override low wakes into start-up, then skips bit-check, settings kept
module pbcs_device (
  input wire logic clk, // Oscillator clock
  input wire logic arst_n, // Async reset, active low
  pbcs_if.device link, // Host-facing pins and configuration
  output logic signal_enable, // Signal processing enable
  output logic [3:0] mode_state // Current polling mode, one-hot
);
  import pbcs_pkg::*;
  logic base_tick, extended_tick;
  logic [4:0] sleep_q, sleep_d;
  logic ext_sel_q, ext_sel_d;
  logic [1:0] baud_range_select, baud_d;
  logic [1:0] nbit_q, nbit_d;
  logic [4:0] lim_min_q, lim_min_d, lim_max_q, lim_max_d;
  logic [1:0] ovr_s_q, dem_s_q;
  logic dem_prev_q, dem_prev_d;
  pbcs_state_t st_q, st_d;
  logic [17:0] sleep_cnt_q, sleep_cnt_d;
  logic [4:0] start_cnt_q, start_cnt_d;
  logic [5:0] edge_interval_counter, eic_d;
  logic [4:0] pass_q, pass_d;
  logic act_q, act_d, en_q, en_d, recv_q, recv_d;
  logic [17:0] sleep_target;
  logic ovr_low, edge_seen;

  pbcs_tick_gen pbcs_tick_gen_inst (
    .clk(clk),
    .arst_n(arst_n),
    .baud_range_select(baud_range_select),
    .base_tick(base_tick),
    .extended_tick(extended_tick)
  );

  // Pins from the host side are asynchronous to the oscillator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_s_q <= 2'h3;
      dem_s_q <= 2'h0;
    end else begin
      ovr_s_q <= {ovr_s_q[0], link.poll_override_n};
      dem_s_q <= {dem_s_q[0], link.demod_out};
    end
  end
  assign ovr_low = !ovr_s_q[1];

  always_comb begin
    sleep_d = sleep_q;
    ext_sel_d = ext_sel_q;
    baud_d = baud_range_select;
    nbit_d = nbit_q;
    lim_min_d = lim_min_q;
    lim_max_d = lim_max_q;
    if (link.cfg_we) begin
      sleep_d = link.cfg_sleep;
      ext_sel_d = link.cfg_sleep_ext;
      baud_d = link.cfg_baud;
      nbit_d = link.cfg_nbit;
      lim_min_d = link.cfg_lim_min;
      lim_max_d = link.cfg_lim_max;
    end
  end

  always_comb begin
    // Sleep is counted in base ticks; extension factor folds into the target
    sleep_target = {3'h0, sleep_q, 10'h000} * 18'(ext_sel_q ? SLEEP_XFACT : 1);
    edge_seen = extended_tick && (dem_s_q[1] != dem_prev_q);
    dem_prev_d = extended_tick ? dem_s_q[1] : dem_prev_q;
    st_d = st_q;
    sleep_cnt_d = sleep_cnt_q;
    start_cnt_d = start_cnt_q;
    eic_d = edge_interval_counter;
    pass_d = pass_q;
    case (st_q)
      PBCS_SLEEP: begin
        if (ovr_low) begin
          st_d = PBCS_START;
        end else if (sleep_q == SLEEP_PERM) begin
          sleep_cnt_d = 18'h0_0000;
        end else if (base_tick) begin
          if (sleep_cnt_q + 18'h0_0001 >= sleep_target) begin
            st_d = PBCS_START;
          end else begin
            sleep_cnt_d = sleep_cnt_q + 18'h0_0001;
          end
        end
        start_cnt_d = 5'h00;
      end
      PBCS_START: begin
        // Demodulator output is not looked at while circuits settle
        if (extended_tick) begin
          start_cnt_d = start_cnt_q + 5'h01;
          if (start_cnt_q == 5'(STARTUP_XT - 1)) begin
            st_d = PBCS_CHECK;
            eic_d = 6'h00;
            pass_d = 5'h00;
          end
        end
      end
      PBCS_CHECK: begin
        if (!ovr_low && pass_q >= pbcs_checks(nbit_q)) begin
          st_d = PBCS_RECV;
        end else if (ovr_low && pass_q >= pbcs_checks(2'h0)) begin
          st_d = PBCS_RECV;
        end else if (extended_tick) begin
          if (edge_seen) begin
            if ({1'b0, lim_min_q} > edge_interval_counter) begin
              st_d = PBCS_SLEEP;
            end else begin
              pass_d = pass_q + 5'h01;
              eic_d = 6'h00;
            end
          end else if (edge_interval_counter + 6'h01 >= {1'b0, lim_max_q}) begin
            st_d = PBCS_SLEEP;
          end else begin
            eic_d = edge_interval_counter + 6'h01;
          end
        end
      end
      PBCS_RECV: begin
        if (link.back_to_poll) begin
          st_d = PBCS_SLEEP;
        end
      end
      default: st_d = PBCS_SLEEP;
    endcase
    if (st_d == PBCS_SLEEP && st_q != PBCS_SLEEP) begin
      sleep_cnt_d = 18'h0_0000;
    end
    act_d = (st_d != PBCS_SLEEP);
    en_d = (st_d != PBCS_SLEEP);
    recv_d = (st_d == PBCS_RECV);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_q <= SLEEP_RST;
      ext_sel_q <= 1'b0;
      baud_range_select <= BR_RST;
      nbit_q <= NBIT_RST;
      lim_min_q <= LIM_MIN_RST;
      lim_max_q <= LIM_MAX_RST;
      dem_prev_q <= 1'b0;
      st_q <= PBCS_SLEEP;
      sleep_cnt_q <= 18'h0_0000;
      start_cnt_q <= 5'h00;
      edge_interval_counter <= 6'h00;
      pass_q <= 5'h00;
      act_q <= 1'b0;
      en_q <= 1'b0;
      recv_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      ext_sel_q <= ext_sel_d;
      baud_range_select <= baud_d;
      nbit_q <= nbit_d;
      lim_min_q <= lim_min_d;
      lim_max_q <= lim_max_d;
      dem_prev_q <= dem_prev_d;
      st_q <= st_d;
      sleep_cnt_q <= sleep_cnt_d;
      start_cnt_q <= start_cnt_d;
      edge_interval_counter <= eic_d;
      pass_q <= pass_d;
      act_q <= act_d;
      en_q <= en_d;
      recv_q <= recv_d;
    end
  end

  assign link.activity_indicator_pin = act_q;
  assign link.receiving = recv_q;
  assign signal_enable = en_q;
  assign mode_state = st_q;
endmodule

// [verilog/pbcs_host.sv]
`timescale 1ns/1ns
module pbcs_host (
  input wire logic clk, // Host clock
  input wire logic arst_n, // Async reset, active low
  pbcs_if.host link, // Receiver-facing pins
  input wire logic usr_cfg_we, // Pulse: load configuration below
  input wire logic [4:0] usr_sleep, // Sleep value
  input wire logic usr_sleep_ext, // Sleep extension select
  input wire logic [1:0] usr_baud, // Baud range
  input wire logic [1:0] usr_nbit, // Check bit count field
  input wire logic [4:0] usr_lim_min, // Lower limit
  input wire logic [4:0] usr_lim_max, // Upper limit
  input wire logic usr_force_on, // Hold receiver awake via override
  input wire logic usr_back_to_poll, // Pulse: return to polling
  output logic usr_active, // Synchronised activity indicator
  output logic usr_receiving // Synchronised receiving flag
);
  import pbcs_pkg::*;
  logic we_q, we_d, ovr_n_q, ovr_n_d, btp_q, btp_d;
  logic [4:0] sleep_q, lmin_q, lmax_q, lmin_d;
  logic ext_q;
  logic [1:0] baud_q, nbit_q;
  logic [1:0] act_s_q, rx_s_q;

  always_comb begin
    // Clamp lower limit to the smallest safe value
    lmin_d = (usr_lim_min < LIM_MIN_RST) ? LIM_MIN_RST : usr_lim_min;
    we_d = usr_cfg_we;
    ovr_n_d = !usr_force_on;
    btp_d = usr_back_to_poll;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      we_q <= 1'b0;
      ovr_n_q <= 1'b1;
      btp_q <= 1'b0;
      sleep_q <= SLEEP_RST;
      ext_q <= 1'b0;
      baud_q <= BR_RST;
      nbit_q <= NBIT_RST;
      lmin_q <= LIM_MIN_RST;
      lmax_q <= LIM_MAX_RST;
      act_s_q <= 2'h0;
      rx_s_q <= 2'h0;
    end else begin
      we_q <= we_d;
      ovr_n_q <= ovr_n_d;
      btp_q <= btp_d;
      if (usr_cfg_we) begin
        sleep_q <= usr_sleep;
        ext_q <= usr_sleep_ext;
        baud_q <= usr_baud;
        nbit_q <= usr_nbit;
        lmin_q <= lmin_d;
        lmax_q <= usr_lim_max;
      end
      act_s_q <= {act_s_q[0], link.activity_indicator_pin};
      rx_s_q <= {rx_s_q[0], link.receiving};
    end
  end

  assign link.cfg_we = we_q;
  assign link.poll_override_n = ovr_n_q;
  assign link.back_to_poll = btp_q;
  assign link.cfg_sleep = sleep_q;
  assign link.cfg_sleep_ext = ext_q;
  assign link.cfg_baud = baud_q;
  assign link.cfg_nbit = nbit_q;
  assign link.cfg_lim_min = lmin_q;
  assign link.cfg_lim_max = lmax_q;
  assign usr_active = act_s_q[1];
  assign usr_receiving = rx_s_q[1];
endmodule

// [verif/pbcs_sva.sv]
`timescale 1ns/1ns
module pbcs_sva (
  input wire logic clk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic poll_override_n, // Override pin
  input wire logic back_to_poll, // Return request
  input wire logic cfg_we, // Config load
  input wire logic [4:0] cfg_sleep, // Sleep value
  input wire logic activity_indicator_pin, // Activity
  input wire logic signal_enable, // Processing enable
  input wire logic [3:0] mode_state // One-hot mode
);
  import pbcs_pkg::*;
  // Two base ticks of slack for the tick phase at entry
  localparam int START_MIN = (STARTUP_XT - 2) * OSC_DIV;
  logic [4:0] slp_q, slp_d;
  logic [11:0] st_q, st_d;
  always_comb begin
    slp_d = cfg_we ? cfg_sleep : slp_q;
    st_d = (mode_state == PBCS_START) ? st_q + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slp_q <= SLEEP_RST;
      st_q <= 12'h000;
    end else begin
      slp_q <= slp_d;
      st_q <= st_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_leave(m);
    mode_state == m ##1 mode_state != m;
  endsequence
  // Override passes two sync stages, so it must be quiet for longer
  sequence s_quiet;
    poll_override_n [*4];
  endsequence
  a_one_hot_mode: assert property ($onehot(mode_state))
    else $error("mode not one-hot");
  a_enable_tracks_act: assert property (signal_enable == activity_indicator_pin)
    else $error("enable differs from activity");
  a_sleep_act_low: assert property ((mode_state == PBCS_SLEEP) [*2] |-> !activity_indicator_pin)
    else $error("activity high in sleep");
  a_awake_act_high: assert property ((mode_state != PBCS_SLEEP) [*2] |-> activity_indicator_pin)
    else $error("activity low while awake");
  a_sleep_to_start: assert property (s_leave(PBCS_SLEEP) |-> mode_state == PBCS_START)
    else $error("sleep left to wrong mode");
  a_start_to_check: assert property (s_leave(PBCS_START) |-> mode_state == PBCS_CHECK && st_q >= START_MIN)
    else $error("start-up left early or wrongly");
  a_check_exit_mode: assert property (s_leave(PBCS_CHECK) |-> mode_state inside {PBCS_SLEEP, PBCS_RECV})
    else $error("check left to wrong mode");
  a_recv_holds_on: assert property (mode_state == PBCS_RECV && !back_to_poll && !$past(back_to_poll) |=> mode_state == PBCS_RECV)
    else $error("receiving left without request");
  a_perm_sleep_stays: assert property (s_quiet ##0 (mode_state == PBCS_SLEEP && slp_q == SLEEP_PERM && !cfg_we) |=> mode_state == PBCS_SLEEP)
    else $error("permanent sleep left");
  a_override_wakes_up: assert property ((!poll_override_n) [*5] |-> !(mode_state == PBCS_SLEEP && $past(mode_state) == PBCS_SLEEP))
    else $error("override did not wake");
endmodule

// [verif/polling_bit_check_sequencer_bench.sv]
`timescale 1ns/1ns
module polling_bit_check_sequencer_bench;
  import pbcs_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, we = 1'b0, force_on = 1'b0, back = 1'b0, ext = 1'b0;
  logic [4:0] slp = 5'h00, lmax = 5'h18;
  logic [1:0] baud = 2'h0, nbit = 2'h0;
  logic act, rcv, en;
  logic [3:0] mode;
  int num_errors = 0, n_tests = 0, cyc = 0, d;
  pbcs_if link_if ();
  pbcs_host pbcs_host_inst (.clk(clk), .arst_n(arst_n), .link(link_if.host), .usr_cfg_we(we),
    .usr_sleep(slp), .usr_sleep_ext(ext), .usr_baud(baud), .usr_nbit(nbit),
    .usr_lim_min(5'h0A), .usr_lim_max(lmax), .usr_force_on(force_on),
    .usr_back_to_poll(back), .usr_active(act), .usr_receiving(rcv));
  pbcs_device pbcs_device_inst (.clk(clk), .arst_n(arst_n), .link(link_if.device),
    .signal_enable(en), .mode_state(mode));
  pbcs_sva pbcs_sva_inst (.clk(clk), .arst_n(arst_n), .poll_override_n(link_if.poll_override_n),
    .back_to_poll(link_if.back_to_poll), .cfg_we(link_if.cfg_we), .cfg_sleep(link_if.cfg_sleep),
    .activity_indicator_pin(link_if.activity_indicator_pin), .signal_enable(en), .mode_state(mode));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic near(input int a, input int e, input int tol);
    return (a >= e - tol) && (a <= e + tol);
  endfunction
  function automatic int xt(input logic [1:0] b);
    return OSC_DIV * (8 >> b);
  endfunction
  task automatic wait_mode(input logic [3:0] m, input int lim);
    d = 0;
    while (mode !== m && d < lim) begin
      @(negedge clk);
      d++;
    end
    chk("mode", mode, m);
  endtask
  task automatic cfg(input logic [4:0] s, input logic [1:0] b, input logic [1:0] n,
    input logic [4:0] hi);
    @(negedge clk);
    slp = s;
    baud = b;
    nbit = n;
    lmax = hi;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic pulse_back();
    @(negedge clk);
    back = 1'b1;
    @(negedge clk);
    back = 1'b0;
  endtask
  // Edges 12 or 13 ticks apart sit inside the window despite sync delay
  task automatic run_check(input int good, input int bad);
    wait_mode(PBCS_CHECK, 4000);
    for (int i = 0; i < good; i++) begin
      repeat ((12 + $urandom_range(1)) * xt(baud)) @(negedge clk);
      link_if.demod_out = ~link_if.demod_out;
    end
    if (bad > 0) begin
      repeat (bad * xt(baud)) @(negedge clk);
      link_if.demod_out = ~link_if.demod_out;
    end
  endtask
  task automatic final_report();
    $display("counts errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    link_if.demod_out = 1'b0;
    void'($urandom(64));
    repeat (12) @(negedge clk);
    chk("act_rst", link_if.activity_indicator_pin, 1'b0);
    arst_n = 1'b1;
    wait_mode(PBCS_RECV, 2500);
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      cfg(5'h00, 2'(b), 2'h0, 5'h18);
      pulse_back();
      wait_mode(PBCS_START, 100);
      wait_mode(PBCS_CHECK, 2000);
      chk("startup", near(d, STARTUP_XT * xt(2'(b)), xt(2'(b)) + 3), 1'b1);
      wait_mode(PBCS_RECV, 50);
      chk("active", link_if.activity_indicator_pin, 1'b1);
    end
    $display("test baud done");
    cfg(5'h01, 2'h3, 2'h0, 5'h18);
    pulse_back();
    wait_mode(PBCS_SLEEP, 50);
    chk("enable", en, 1'b0);
    wait_mode(PBCS_START, 20000);
    chk("sleep", near(d, SLEEP_UNIT * OSC_DIV, OSC_DIV + 3), 1'b1);
    wait_mode(PBCS_RECV, 400);
    ext = 1'b1;
    cfg(5'h01, 2'h3, 2'h0, 5'h18);
    pulse_back();
    wait_mode(PBCS_SLEEP, 50);
    repeat (16000) @(negedge clk);
    chk("sleep_ext", mode, PBCS_SLEEP);
    ext = 1'b0;
    $display("test sleep done");
    // Small lower limit, so the longer check counts are exercised
    for (int n = 0; n < 4; n++) begin
      cfg(5'h00, 2'h3, 2'(n), 5'(16 + $urandom_range(8)));
      pulse_back();
      run_check(6 * n, 0);
      wait_mode(PBCS_RECV, 100);
    end
    repeat (3) @(negedge clk);
    chk("usr_rcv", rcv, 1'b1);
    chk("usr_act", act, 1'b1);
    $display("test checks done");
    cfg(5'h00, 2'h3, 2'h1, 5'h10);
    pulse_back();
    run_check(0, 5);
    wait_mode(PBCS_SLEEP, 100);
    run_check(3, 0);
    wait_mode(PBCS_SLEEP, 400);
    chk("no_recv", link_if.receiving, 1'b0);
    $display("test fails done");
    cfg(SLEEP_PERM, 2'h3, 2'h3, 5'h10);
    wait_mode(PBCS_SLEEP, 1000);
    repeat (3000) @(negedge clk);
    chk("perm", mode, PBCS_SLEEP);
    force_on = 1'b1;
    wait_mode(PBCS_START, 10);
    wait_mode(PBCS_RECV, 400);
    force_on = 1'b0;
    repeat (8) @(negedge clk);
    chk("hold", mode, PBCS_RECV);
    pulse_back();
    wait_mode(PBCS_SLEEP, 50);
    repeat (2000) @(negedge clk);
    chk("perm", mode, PBCS_SLEEP);
    cfg(5'h00, 2'h3, 2'h0, 5'h10);
    wait_mode(PBCS_RECV, 600);
    $display("test override done");
    final_report();
  end
endmodule
